//--- fpc_regs.svh
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
// Command codes
`define CMD_FEATURE 8'hD1
`define CMD_SENSE 8'hD2
`define CMD_PHASE 8'hD3
// Feature word fields
`define FW_MINDUTY_HI 15
`define FW_MINDUTY_LO 11
`define FW_MINDUTY_EN 7
`define FW_VSEL 5
`define FW_LSD_LVL 3
`define FW_PG_PP 2
`define FW_XT_EN 1
`define FW_XT_FLT 0
`define FW_MASK 16'hF8AF
// Sense impedance reset (2 milliohm)
`define SENSE_RST 16'hC200
`define SENSE_EXP_HI 15
`define SENSE_EXP_LO 11
// Minimum duty denominator 512 is a shift by 9
`define DUTY_SHIFT 9
`endif

//--- fpc_pkg.sv
package fpc_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] wdata;
        logic page;
    } bus_req_t;
    typedef struct packed {
        logic [4:0] min_duty;
        logic min_duty_en;
        logic vsel;
        logic lsd_level;
        logic pg_push_pull;
        logic xt_en;
        logic xt_fault;
    } feat_t;
endpackage : fpc_pkg

//--- chan_outputs.sv
`timescale 1ns/1ps
`include "fpc_regs.svh"
// Per-channel pin behaviour derived from the feature word
module chan_outputs
    import fpc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [15:0] feat,
    input wire logic enabled,
    input wire logic pwm_in,
    input wire logic pg_level,
    input wire logic strap_a,
    input wire logic strap_b,
    input wire logic xt_valid,
    input wire logic xt_over,
    input wire logic int_over,
    output logic low_side_drive,
    output logic power_ok_out,
    output logic power_ok_oe,
    output logic strap_sel,
    output logic temp_fault,
    output logic duty_floor_en,
    output logic [9:0] duty_floor_num
);
    // Outputs registered so pins never glitch on a config write
    always_ff @(posedge mclk) begin
        if (srst) begin
            low_side_drive <= 1'b0;
            power_ok_out <= 1'b0;
            power_ok_oe <= 1'b1;
            strap_sel <= 1'b0;
            temp_fault <= 1'b0;
            duty_floor_en <= 1'b0;
            duty_floor_num <= 10'h000;
        end else begin
            low_side_drive <= enabled ? pwm_in : feat[`FW_LSD_LVL];
            // Open-drain only drives low; push-pull drives both levels
            power_ok_out <= pg_level;
            power_ok_oe <= feat[`FW_PG_PP] | ~pg_level;
            strap_sel <= feat[`FW_VSEL] ? strap_b : strap_a;
            // External reading counts only when enabled and chosen as source
            if (feat[`FW_XT_EN] && feat[`FW_XT_FLT]) begin
                temp_fault <= xt_valid & xt_over;
            end else begin
                temp_fault <= int_over;
            end
            duty_floor_en <= feat[`FW_MINDUTY_EN];
            // Floor = 2*(v+1)/512, numerator over 512
            // Six-bit sum so a field of 31 gives 32, then doubled to 64
            duty_floor_num <= {3'h0, {1'b0, feat[`FW_MINDUTY_HI:`FW_MINDUTY_LO]} + 6'h01,
                1'b0};
        end
    end
endmodule : chan_outputs

//--- feature_and_phase_config_regs.sv
`timescale 1ns/1ps
`include "fpc_regs.svh"
module feature_and_phase_config_regs
    import fpc_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input wire logic mclk,
    input wire logic srst,
    input wire bus_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic cmd_ok,
    input wire logic cfg_straps_used,
    input wire logic [15:0] cfg_strap_feature,
    input wire logic [15:0] addr_strap_phase,
    input wire logic [CHANNELS-1:0] chan_enabled,
    input wire logic [CHANNELS-1:0] pwm_in,
    input wire logic [CHANNELS-1:0] pg_level,
    input wire logic voltage_strap_a,
    input wire logic voltage_strap_b,
    input wire logic external_temp_valid,
    input wire logic external_temp_over,
    input wire logic internal_temp_over,
    output logic [CHANNELS-1:0] low_side_drive,
    output logic [CHANNELS-1:0] power_ok_output,
    output logic [CHANNELS-1:0] power_ok_oe,
    output logic [CHANNELS-1:0] strap_sel,
    output logic [CHANNELS-1:0] temp_fault,
    output logic [CHANNELS-1:0] duty_floor_en,
    output logic [CHANNELS*10-1:0] duty_floor_num,
    output logic [15:0] sense_impedance,
    output logic [CHANNELS*16-1:0] phase_group
);
    logic [15:0] feat_r [CHANNELS];
    logic [15:0] phase_r [CHANNELS];
    logic [15:0] sense_r;
    logic load_r;
    logic sa_m, sa_s, sb_m, sb_s, xv_m, xv_s, xo_m, xo_s;
    logic [CHANNELS-1:0] pg_m, pg_s;

    // Decode the three supported command codes
    function automatic logic is_ours(input logic [7:0] c);
        return (c == `CMD_FEATURE) || (c == `CMD_SENSE) || (c == `CMD_PHASE);
    endfunction : is_ours

    // Voltage strap, external temperature and power-good inputs pass two flops before use; internal_temp_over and the config straps do not
    always_ff @(posedge mclk) begin
        sa_m <= voltage_strap_a;
        sa_s <= sa_m;
        sb_m <= voltage_strap_b;
        sb_s <= sb_m;
        xv_m <= external_temp_valid;
        xv_s <= xv_m;
        xo_m <= external_temp_over;
        xo_s <= xo_m;
        pg_m <= pg_level;
        pg_s <= pg_m;
    end

    // Straps are caught the cycle after reset release, not inside reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            load_r <= 1'b1;
        end else begin
            load_r <= 1'b0;
        end
    end

    // Paged feature and phase registers
    always_ff @(posedge mclk) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (srst) begin
                feat_r[i] <= 16'h0000;
                phase_r[i] <= 16'h0000;
            end else if (load_r) begin
                feat_r[i] <= cfg_strap_feature & `FW_MASK;
                if (cfg_straps_used) begin
                    phase_r[i] <= addr_strap_phase;
                end
            end else if (req.wr && (int'(req.page) == i)) begin
                if (req.cmd == `CMD_FEATURE) begin
                    feat_r[i] <= req.wdata & `FW_MASK;
                end
                // Whole word kept; its field layout is decoded elsewhere
                if (req.cmd == `CMD_PHASE) begin
                    phase_r[i] <= req.wdata;
                end
            end
        end
    end

    // Global sense impedance, stored raw in its float format
    always_ff @(posedge mclk) begin
        if (srst) begin
            sense_r <= `SENSE_RST;
        end else if (req.wr && req.cmd == `CMD_SENSE) begin
            sense_r <= req.wdata;
        end
    end

    // Read port answers one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata <= 16'h0000;
            rvalid <= 1'b0;
            cmd_ok <= 1'b0;
        end else begin
            rvalid <= req.rd;
            cmd_ok <= (req.rd | req.wr) & is_ours(req.cmd);
            case (req.cmd)
                `CMD_FEATURE: rdata <= req.rd ? feat_r[req.page] : 16'h0000;
                `CMD_SENSE: rdata <= req.rd ? sense_r : 16'h0000;
                `CMD_PHASE: rdata <= req.rd ? phase_r[req.page] : 16'h0000;
                default: rdata <= 16'h0000;
            endcase
        end
    end

    // Value used by the input current computation
    assign sense_impedance = sense_r;

    // Per-channel pin logic
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        assign phase_group[g*16 +: 16] = phase_r[g];
        chan_outputs u_ch (
            .mclk(mclk),
            .srst(srst),
            .feat(feat_r[g]),
            .enabled(chan_enabled[g]),
            .pwm_in(pwm_in[g]),
            .pg_level(pg_s[g]),
            .strap_a(sa_s),
            .strap_b(sb_s),
            .xt_valid(xv_s),
            .xt_over(xo_s),
            .int_over(internal_temp_over),
            .low_side_drive(low_side_drive[g]),
            .power_ok_out(power_ok_output[g]),
            .power_ok_oe(power_ok_oe[g]),
            .strap_sel(strap_sel[g]),
            .temp_fault(temp_fault[g]),
            .duty_floor_en(duty_floor_en[g]),
            .duty_floor_num(duty_floor_num[g*10 +: 10])
        );
    end
endmodule : feature_and_phase_config_regs

//--- pg_pin_model.sv
`timescale 1ns/1ps
// Power-good wire; a released wire reads high through the board pull-up
module pg_pin_model (
    input wire logic [1:0] drive,
    input wire logic [1:0] oe,
    output logic [1:0] level
);
    assign level = (oe & drive) | ~oe;
endmodule : pg_pin_model

//--- feature_and_phase_config_regs_checker.sv
`timescale 1ns/1ps
// Port checks of the config bank
module fpc_checker
    import fpc_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input wire logic mclk,
    input wire logic srst,
    input wire bus_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic cmd_ok,
    input wire logic [CHANNELS-1:0] chan_enabled,
    input wire logic [CHANNELS-1:0] low_side_drive,
    input wire logic [CHANNELS-1:0] power_ok_output,
    input wire logic [CHANNELS-1:0] power_ok_oe,
    input wire logic [CHANNELS-1:0] duty_floor_en,
    input wire logic [CHANNELS*10-1:0] duty_floor_num,
    input wire logic [15:0] sense_impedance
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Bus answers one cycle after the request
    a_read_answer: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    a_idle_quiet: assert property (!req.rd |=> !rvalid && rdata == 16'h0000)
        else $error("read data without read");
    a_cmd_known: assert property (req.wr || req.rd |=>
        cmd_ok == ($past(req.cmd) inside {8'hd1, 8'hd2, 8'hd3})) else $error("cmd_ok wrong");
    a_sense_read: assert property (req.rd && req.cmd == 8'hd2 |=>
        rdata == $past(sense_impedance)) else $error("sense read wrong");
    a_sense_write: assert property (req.wr && req.cmd == 8'hd2 |=>
        sense_impedance == $past(req.wdata)) else $error("sense write lost");
    a_feat_unused: assert property (req.rd && req.cmd == 8'hd1 |=>
        (rdata & 16'h0750) == 16'h0000) else $error("unused bits set");
    // Pins follow a channel 0 write two cycles later
    a_duty_floor: assert property (req.wr && req.cmd == 8'hd1 && !req.page |=> ##1
        duty_floor_num[9:0] == 10'(2 * ($past(req.wdata[15:11], 2) + 1))
        && duty_floor_en[0] == $past(req.wdata[7], 2)) else $error("duty floor wrong");
    a_lsd_level: assert property (req.wr && req.cmd == 8'hd1 && !req.page
        ##1 (!chan_enabled[0]) [*2] |-> low_side_drive[0] == $past(req.wdata[3], 2))
        else $error("low side level wrong");
    a_pg_drain: assert property (req.wr && req.cmd == 8'hd1 && !req.page && !req.wdata[2]
        |=> ##1 (!power_ok_oe[0] || !power_ok_output[0])) else $error("open drain high");
    c_feat_wr: cover property (req.wr && req.cmd == 8'hd1);
    c_bad_cmd: cover property (req.rd && req.cmd == 8'h55);
    c_sense_rst: cover property (rvalid && rdata == 16'hc200);
endmodule : fpc_checker
bind feature_and_phase_config_regs fpc_checker #(.CHANNELS(CHANNELS)) i_chk (.mclk, .srst,
    .req, .rdata, .rvalid, .cmd_ok, .chan_enabled, .low_side_drive, .power_ok_output,
    .power_ok_oe, .duty_floor_en, .duty_floor_num, .sense_impedance);

//--- feature_and_phase_config_regs_test.sv
`timescale 1ns/1ps
module feature_and_phase_config_regs_test;
    import fpc_pkg::*;
    localparam logic [15:0] SFEAT = 16'h5a5a;
    localparam logic [15:0] SPHASE = 16'h0312;
    logic mclk = 0;
    logic srst = 1;
    bus_req_t req = '0;
    logic [15:0] rdata, sense;
    logic rvalid, cmd_ok;
    logic [1:0] en = 2'b11;
    logic [6:0] misc = 7'h00;
    logic [1:0] lsd, pgo, pgoe, pgl, den, ss, tf;
    logic [19:0] dnum;
    logic [31:0] phase;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #50 mclk = ~mclk;
    feature_and_phase_config_regs i_dut (.mclk(mclk), .srst(srst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .cmd_ok(cmd_ok), .cfg_straps_used(1'b1), .cfg_strap_feature(SFEAT),
        .addr_strap_phase(SPHASE), .chan_enabled(en), .pwm_in(misc[1:0]), .pg_level(pgl),
        .voltage_strap_a(misc[2]), .voltage_strap_b(misc[3]), .external_temp_valid(misc[4]),
        .external_temp_over(misc[5]), .internal_temp_over(misc[6]), .low_side_drive(lsd),
        .power_ok_output(pgo), .power_ok_oe(pgoe), .strap_sel(ss), .temp_fault(tf),
        .duty_floor_en(den), .duty_floor_num(dnum), .sense_impedance(sense), .phase_group(phase));
    pg_pin_model i_pg (.drive(pgo), .oe(pgoe), .level(pgl));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One request, judged once its answer has landed
    task automatic xfer(input logic wr, input logic [7:0] cmd, input logic pg,
            input logic [15:0] wd, input logic [15:0] exp);
        @(posedge mclk);
        req <= '{wr: wr, rd: !wr, cmd: cmd, wdata: wd, page: pg};
        @(posedge mclk);
        req <= '0;
        // Answer stands for the one cycle after the taking edge
        #1;
        chk("cmd_ok", 16'(cmd inside {8'hd1, 8'hd2, 8'hd3}), 16'(cmd_ok));
        chk("rvalid", 16'(!wr), 16'(rvalid));
        if (!wr) chk("rdata", exp, rdata);
    endtask : xfer
    task automatic t_reset();
        xfer(0, 8'hd1, 1, 16'h0000, SFEAT & 16'hf8af);
        xfer(0, 8'hd2, 0, 16'h0000, 16'hc200);
        xfer(0, 8'hd3, 1, 16'h0000, SPHASE);
        $display("done reset values");
    endtask : t_reset
    task automatic t_regs();
        xfer(1, 8'hd1, 1, 16'hffff, 16'h0000);
        xfer(0, 8'hd1, 1, 16'h0000, 16'hf8af);
        xfer(0, 8'hd1, 0, 16'h0000, SFEAT & 16'hf8af);
        xfer(1, 8'hd2, 1, 16'hd3ff, 16'h0000);
        xfer(0, 8'hd2, 0, 16'h0000, 16'hd3ff);
        xfer(1, 8'hd3, 0, 16'h2200, 16'h0000);
        xfer(1, 8'hd3, 1, 16'h2201, 16'h0000);
        xfer(0, 8'hd3, 0, 16'h0000, 16'h2200);
        // This page 1 word is read back at once, right after the write has already taken effect
        xfer(1, 8'hd3, 1, 16'h4402, 16'h0000);
        xfer(0, 8'hd3, 1, 16'h0000, 16'h4402);
        xfer(0, 8'h55, 0, 16'h0000, 16'h0000);
        $display("done register access");
    endtask : t_regs
    // Disabled channel 0: floor, floor enable and drive level follow the word
    task automatic t_pins();
        en <= 2'b10;
        misc <= 7'h7f;
        xfer(1, 8'hd1, 0, 16'hf88c, 16'h0000);
        @(posedge mclk);
        #1;
        chk("lsd", 16'h0001, 16'(lsd[0]));
        chk("floor", 16'h0040, 16'(dnum[9:0]));
        chk("floor_en", 16'h0001, 16'(den[0]));
        xfer(1, 8'hd1, 0, 16'h0000, 16'h0000);
        @(posedge mclk);
        #1;
        chk("lsd", 16'h0000, 16'(lsd[0]));
        chk("floor", 16'h0002, 16'(dnum[9:0]));
        chk("floor_en", 16'h0000, 16'(den[0]));
        $display("done pin behaviour");
    endtask : t_pins
    task automatic summarize();
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // Hang guard: a stuck run counts as a mismatch
    initial begin
        repeat (2000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 0;
        t_reset();
        t_regs();
        t_pins();
        summarize();
    end
endmodule : feature_and_phase_config_regs_test
